//--- line_unit_model.sv
// Line interface model: counts transmit clock rises and takes the pulse pair.
`timescale 1ns/100ps
`default_nettype none
module line_unit_model
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic line_clk_i,
    input wire logic pos_i,
    input wire logic neg_i,
    output logic [15:0] rise_count_o,
    output logic [1:0] last_bits_o
);
    // ----
    // Receiver
    // ----
    logic prev;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev <= 1'b0;
            rise_count_o <= 16'h0;
            last_bits_o <= 2'b00;
        end
        else
        begin
            prev <= line_clk_i;
            if (line_clk_i && !prev)
            begin
                rise_count_o <= rise_count_o + 16'h1;
                last_bits_o <= {pos_i, neg_i};
            end
        end
    end
endmodule
`default_nettype wire

//--- t1_txclk.sv
// Four-channel T1 transmit clock selection, line output shaping and FIFO flag.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "t1_txclk_defs.svh"

module t1_txclk
(
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    input wire logic [3:0] TX_CLOCK_IN_I,
    input wire logic [3:0] BACKPLANE_TX_CLOCK_I,
    input wire logic [3:0] RECOVERED_RX_CLOCK_I,
    input wire logic [3:0] TX_POS_DATA_I,
    input wire logic [3:0] TX_NEG_DATA_I,
    input wire logic [3:0] TX_SERIAL_DATA_I,
    output logic [3:0] TX_CLOCK_OUT_O,
    output logic [3:0] TX_POS_PULSE_OUT_O,
    output logic [3:0] TX_NEG_PULSE_OUT_O,
    output logic IRQ_O,
    input wire logic [7:0] AXI_AWADDR_I,
    input wire logic AXI_AWVALID_I,
    output logic AXI_AWREADY_O,
    input wire logic [31:0] AXI_WDATA_I,
    input wire logic [3:0] AXI_WSTRB_I,
    input wire logic AXI_WVALID_I,
    output logic AXI_WREADY_O,
    output logic [1:0] AXI_BRESP_O,
    output logic AXI_BVALID_O,
    input wire logic AXI_BREADY_I,
    input wire logic [7:0] AXI_ARADDR_I,
    input wire logic AXI_ARVALID_I,
    output logic AXI_ARREADY_O,
    output logic [31:0] AXI_RDATA_O,
    output logic [1:0] AXI_RRESP_O,
    output logic AXI_RVALID_O,
    input wire logic AXI_RREADY_I
);

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [5:0] fill_step(input logic [5:0] fill,
                                             input logic up,
                                             input logic down);
        logic [5:0] res;
        res = fill;
        if (up && !down && fill != `FIFO_MAX)
        begin
            res = fill + 6'h01;
        end
        else if (down && !up && fill != `FIFO_MIN)
        begin
            res = fill - 6'h01;
        end
        return res;
    endfunction

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    t1_txclk_pkg::state_s s;
    t1_txclk_pkg::state_s next_s;
    logic rst_n;

    // Reset is released through two flops; only the second one is used.
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            rst_n <= 1'b0;
        end
        else
        begin
            rst_n <= s.rst_meta;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            s <= '0;
        end
        else if (!rst_n)
        begin
            s <= '0;
            s.rst_meta <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------------
    // Channel logic and register bus
    // ----------------------------------------------------------------------
    always_comb
    begin
        t1_txclk_pkg::tx_src_e src;
        logic ref_in;
        logic sel;
        logic rise;
        logic wr_tick;
        logic frame;
        logic carry;
        logic tc_rise;
        logic tc_fall;
        logic upd;
        logic clr;
        logic [9:0] err;
        logic [23:0] acc_sum;
        logic [7:0] ev;
        logic [31:0] wval;
        logic [31:0] rval;
        logic [1:0] resp;
        logic [7:0] waddr;
        logic [7:0] raddr;
        src = t1_txclk_pkg::SRC_DIV8;
        ref_in = 1'b0;
        sel = 1'b0;
        rise = 1'b0;
        wr_tick = 1'b0;
        frame = 1'b0;
        carry = 1'b0;
        tc_rise = 1'b0;
        tc_fall = 1'b0;
        upd = 1'b0;
        clr = 1'b0;
        err = '0;
        acc_sum = '0;
        ev = '0;
        wval = '0;
        rval = '0;
        resp = `RESP_OKAY;
        waddr = {s.aw_addr[7:2], 2'b00};
        raddr = {AXI_ARADDR_I[7:2], 2'b00};
        next_s = s;
        for (int i = 0; i < 4; i++)
        begin
            src = t1_txclk_pkg::tx_src_e'(s.cfg[i][`CFG_SRC_MSB:`CFG_SRC_LSB]);
            ref_in = s.cfg[i][`CFG_LOOP] ? RECOVERED_RX_CLOCK_I[i] : TX_CLOCK_IN_I[i];
            unique case (src)
                t1_txclk_pkg::SRC_DIV8, t1_txclk_pkg::SRC_JAT: sel = ref_in;
                t1_txclk_pkg::SRC_BACKPLANE: sel = BACKPLANE_TX_CLOCK_I[i];
                t1_txclk_pkg::SRC_RECOVERED: sel = RECOVERED_RX_CLOCK_I[i];
            endcase
            next_s.src_prev[i] = sel;
            rise = sel && !s.src_prev[i];
            wr_tick = 1'b0;
            frame = 1'b0;
            unique case (src)
                t1_txclk_pkg::SRC_DIV8:
                begin
                    if (rise)
                    begin
                        next_s.div_cnt[i] = s.div_cnt[i] + 3'h1;
                        if (s.div_cnt[i][1:0] == `DIV8_TOGGLE)
                        begin
                            next_s.tx_clock_out[i] = !s.tx_clock_out[i];
                        end
                        wr_tick = (s.div_cnt[i] == `DIV8_LAST);
                    end
                end
                t1_txclk_pkg::SRC_JAT:
                begin
                    {carry, acc_sum} = {1'b0, s.acc[i]}
                                       + {1'b0, 24'(`NCO_NOMINAL + s.freq_ofs[i])};
                    next_s.acc[i] = acc_sum;
                    if (carry)
                    begin
                        next_s.tx_clock_out[i] = !s.tx_clock_out[i];
                    end
                    if (rise)
                    begin
                        next_s.div_cnt[i] = s.div_cnt[i] + 3'h1;
                        wr_tick = (s.div_cnt[i] == `DIV8_LAST);
                        // divide reference down to 8 kHz
                        if (s.ref_cnt[i] == s.cfg[i][`CFG_REFN_MSB:`CFG_REFN_LSB])
                        begin
                            next_s.ref_cnt[i] = '0;
                            frame = 1'b1;
                        end
                        else
                        begin
                            next_s.ref_cnt[i] = s.ref_cnt[i] + 8'h01;
                        end
                    end
                end
                t1_txclk_pkg::SRC_BACKPLANE, t1_txclk_pkg::SRC_RECOVERED:
                begin
                    next_s.tx_clock_out[i] = sel;
                    wr_tick = rise;
                end
            endcase
            tc_rise = next_s.tx_clock_out[i] && !s.tx_clock_out[i];
            tc_fall = !next_s.tx_clock_out[i] && s.tx_clock_out[i];
            // frequency held at 193 bits per 8 kHz frame
            if (frame)
            begin
                err = s.per_cnt[i] - `BITS_PER_FRAME;
                next_s.freq_ofs[i] = s.freq_ofs[i] - ({{14{err[9]}}, err} << `JA_GAIN);
                next_s.per_cnt[i] = tc_rise ? 10'h001 : 10'h000;
            end
            else if (tc_rise)
            begin
                next_s.per_cnt[i] = s.per_cnt[i] + 10'h001;
            end
            // rate conversion FIFO level and thresholds
            next_s.fill[i] = fill_step(s.fill[i], wr_tick, tc_rise);
            next_s.near_empty[i] = $signed(next_s.fill[i]) <= $signed(`FIFO_NEAR_EMPTY);
            next_s.near_full[i] = $signed(next_s.fill[i]) >= $signed(`FIFO_NEAR_FULL);
            ev[i] = next_s.near_empty[i] && !s.near_empty[i];
            ev[i + 4] = next_s.near_full[i] && !s.near_full[i];
            // update on the selected clock edge
            upd = s.cfg[i][`CFG_FALL] ? tc_fall : tc_rise;
            clr = s.cfg[i][`CFG_FALL] ? tc_rise : tc_fall;
            if (upd)
            begin
                if (!s.cfg[i][`CFG_SINGLE])
                begin
                    next_s.pos[i] = TX_POS_DATA_I[i];
                    next_s.neg[i] = TX_NEG_DATA_I[i];
                end
                else
                begin
                    next_s.pos[i] = TX_SERIAL_DATA_I[i];
                    // flag sampled on the selected edge
                    next_s.neg[i] = s.cfg[i][`CFG_FULL] ? next_s.near_full[i]
                                                        : next_s.near_empty[i];
                end
            end
            else if (clr && s.cfg[i][`CFG_RZ] && !s.cfg[i][`CFG_SINGLE])
            begin
                next_s.pos[i] = 1'b0;
                next_s.neg[i] = 1'b0;
            end
        end
        // Write channel. Address and data may arrive in either order.
        next_s.bvalid = s.bvalid && !AXI_BREADY_I;
        if (s.awready && AXI_AWVALID_I)
        begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = AXI_AWADDR_I;
        end
        if (s.wready && AXI_WVALID_I)
        begin
            next_s.w_held = 1'b1;
            next_s.w_data = AXI_WDATA_I;
            next_s.w_strb = AXI_WSTRB_I;
        end
        if (s.aw_held && s.w_held && !s.bvalid)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `RESP_OKAY;
            unique case (waddr)
                `REG_CFG0, `REG_CFG1, `REG_CFG2, `REG_CFG3:
                begin
                    wval = merge_bytes({16'h0000, s.cfg[waddr[3:2]]}, s.w_data, s.w_strb);
                    next_s.cfg[waddr[3:2]] = wval[15:0];
                end
                `REG_INT_STAT:
                begin
                    wval = merge_bytes(32'h00000000, s.w_data, s.w_strb);
                    next_s.int_stat = s.int_stat & ~wval[7:0];
                end
                `REG_INT_MASK:
                begin
                    wval = merge_bytes({24'h000000, s.int_mask}, s.w_data, s.w_strb);
                    next_s.int_mask = wval[7:0];
                end
                `REG_STATUS:
                    next_s.bresp = `RESP_OKAY;
                default:
                begin
                    next_s.bresp = `RESP_SLVERR;
                end
            endcase
        end
        // A new event wins over a clear written in the same cycle.
        next_s.int_stat = next_s.int_stat | ev;
        next_s.irq = |(next_s.int_stat & next_s.int_mask);
        next_s.awready = !next_s.aw_held;
        next_s.wready = !next_s.w_held;
        // Read channel, one outstanding read.
        next_s.rvalid = s.rvalid && !AXI_RREADY_I;
        if (s.arready && AXI_ARVALID_I)
        begin
            unique case (raddr)
                `REG_CFG0, `REG_CFG1, `REG_CFG2, `REG_CFG3:
                    rval = {16'h0000, s.cfg[raddr[3:2]]};
                `REG_STATUS:
                    rval = {16'h0000, s.near_full, s.near_empty, s.neg, s.tx_clock_out};
                `REG_INT_STAT:
                    rval = {24'h000000, s.int_stat};
                `REG_INT_MASK:
                    rval = {24'h000000, s.int_mask};
                default:
                    resp = `RESP_SLVERR;
            endcase
            next_s.rvalid = 1'b1;
            next_s.rdata = rval;
            next_s.rresp = resp;
        end
        next_s.arready = !next_s.rvalid;
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    assign TX_CLOCK_OUT_O = s.tx_clock_out;
    assign TX_POS_PULSE_OUT_O = s.pos;
    assign TX_NEG_PULSE_OUT_O = s.neg;
    assign IRQ_O = s.irq;
    assign AXI_AWREADY_O = s.awready;
    assign AXI_WREADY_O = s.wready;
    assign AXI_BVALID_O = s.bvalid;
    assign AXI_BRESP_O = s.bresp;
    assign AXI_ARREADY_O = s.arready;
    assign AXI_RVALID_O = s.rvalid;
    assign AXI_RDATA_O = s.rdata;
    assign AXI_RRESP_O = s.rresp;

endmodule

`default_nettype wire

//--- t1_txclk_defs.svh
// Constants for the T1 transmit clock and line output block.
`ifndef T1_TXCLK_DEFS_SVH
`define T1_TXCLK_DEFS_SVH

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define CLK_HZ 64'd40000000
`define TX_CLOCK_OUT_HZ 64'd1544000
`define FRAME_HZ 64'd8000
`define NCO_NOMINAL 24'((`TX_CLOCK_OUT_HZ * 64'd2 * (64'd1 << 24)) / `CLK_HZ)
`define BITS_PER_FRAME 10'(`TX_CLOCK_OUT_HZ / `FRAME_HZ)
`define JA_GAIN 4
`define DIV8_TOGGLE 2'h3
`define DIV8_LAST 3'h7

// --------------------------------------------------------------------------
// Rate conversion FIFO thresholds, as signed offsets from half full
// --------------------------------------------------------------------------
`define FIFO_NEAR_EMPTY 6'h28
`define FIFO_NEAR_FULL 6'h18
`define FIFO_MAX 6'h1f
`define FIFO_MIN 6'h20

// --------------------------------------------------------------------------
// Register map
// --------------------------------------------------------------------------
`define REG_CFG0 8'h00
`define REG_CFG1 8'h04
`define REG_CFG2 8'h08
`define REG_CFG3 8'h0c
`define REG_STATUS 8'h10
`define REG_INT_STAT 8'h14
`define REG_INT_MASK 8'h18
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// --------------------------------------------------------------------------
// Configuration fields, all zero at reset
// --------------------------------------------------------------------------
`define CFG_SRC_LSB 0
`define CFG_SRC_MSB 1
`define CFG_LOOP 2
`define CFG_SINGLE 3
`define CFG_RZ 4
`define CFG_FALL 5
`define CFG_FULL 6
`define CFG_REFN_LSB 8
`define CFG_REFN_MSB 15

`endif

//--- t1_txclk_pkg.sv
// Types for the T1 transmit clock and line output block.
package t1_txclk_pkg;

    typedef enum logic [1:0]
    {
        SRC_DIV8 = 2'b00,
        SRC_JAT = 2'b01,
        SRC_BACKPLANE = 2'b10,
        SRC_RECOVERED = 2'b11
    } tx_src_e;

    typedef struct packed {
        logic rst_meta;
        logic [3:0][15:0] cfg;
        logic [3:0] src_prev;
        logic [3:0][7:0] ref_cnt;
        logic [3:0][2:0] div_cnt;
        logic [3:0][23:0] acc;
        logic [3:0][23:0] freq_ofs;
        logic [3:0][9:0] per_cnt;
        logic [3:0] tx_clock_out;
        logic [3:0] pos;
        logic [3:0] neg;
        logic [3:0][5:0] fill;
        logic [3:0] near_empty;
        logic [3:0] near_full;
        logic [7:0] int_stat;
        logic [7:0] int_mask;
        logic irq;
        logic awready;
        logic aw_held;
        logic [7:0] aw_addr;
        logic wready;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;

endpackage

//--- t1_txclk_properties.sv
// Port-level checks for the T1 transmit clock block.
`timescale 1ns/100ps
`default_nettype none
`include "t1_txclk_defs.svh"
module t1_txclk_properties
(
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    input wire logic [3:0] TX_CLOCK_OUT_O,
    input wire logic [3:0] TX_POS_PULSE_OUT_O,
    input wire logic [3:0] TX_NEG_PULSE_OUT_O,
    input wire logic IRQ_O,
    input wire logic [7:0] AXI_AWADDR_I,
    input wire logic AXI_AWVALID_I,
    input wire logic AXI_AWREADY_O,
    input wire logic [31:0] AXI_WDATA_I,
    input wire logic AXI_WVALID_I,
    input wire logic AXI_WREADY_O,
    input wire logic [1:0] AXI_BRESP_O,
    input wire logic AXI_BVALID_O,
    input wire logic AXI_BREADY_I,
    input wire logic [7:0] AXI_ARADDR_I,
    input wire logic AXI_ARVALID_I,
    input wire logic AXI_ARREADY_O,
    input wire logic [31:0] AXI_RDATA_O,
    input wire logic [1:0] AXI_RRESP_O,
    input wire logic AXI_RVALID_O
);
    // ----
    // Assertions
    // ----
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESETN_I);
    logic wr_both;
    logic ar_take;
    assign wr_both = AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O;
    assign ar_take = AXI_ARVALID_I && AXI_ARREADY_O;
    chk_aw_refused: assert property (AXI_AWVALID_I && AXI_AWREADY_O |=> !AXI_AWREADY_O)
        else $error("address accepted while held");
    chk_ar_refused: assert property (AXI_RVALID_O |-> !AXI_ARREADY_O)
        else $error("read accepted while busy");
    chk_read_resp: assert property (ar_take |=> AXI_RVALID_O && AXI_RRESP_O ==
        ($past(AXI_ARADDR_I) >= 8'h1c ? `RESP_SLVERR : `RESP_OKAY))
        else $error("read response wrong");
    chk_read_zero: assert property (ar_take && AXI_ARADDR_I >= 8'h1c |=> AXI_RDATA_O == 32'h0)
        else $error("unmapped read data");
    chk_write_latency: assert property (wr_both |-> ##2 AXI_BVALID_O)
        else $error("write response late");
    chk_write_error: assert property (wr_both && AXI_AWADDR_I >= 8'h1c |-> ##2
        AXI_BRESP_O == `RESP_SLVERR)
        else $error("unmapped write accepted");
    chk_b_clear: assert property (AXI_BVALID_O && AXI_BREADY_I |=> !AXI_BVALID_O)
        else $error("write response repeated");
    chk_mask_zero: assert property (wr_both && AXI_AWADDR_I == `REG_INT_MASK &&
        AXI_WDATA_I[7:0] == 8'h00 |-> ##3 !IRQ_O)
        else $error("interrupt with mask clear");
    chk_pos_edge: assert property ($changed(TX_POS_PULSE_OUT_O[0]) |-> $changed(TX_CLOCK_OUT_O[0]))
        else $error("pulse moved off clock edge");
    chk_neg_edge: assert property ($changed(TX_NEG_PULSE_OUT_O[0]) |-> $changed(TX_CLOCK_OUT_O[0]))
        else $error("flag moved off clock edge");
    cover property (wr_both && AXI_AWADDR_I >= 8'h1c);
    cover property ($rose(IRQ_O));
    cover property ($rose(TX_NEG_PULSE_OUT_O[0]));
endmodule
bind t1_txclk t1_txclk_properties chk (.SYS_CLK_I, .RESETN_I, .TX_CLOCK_OUT_O,
    .TX_POS_PULSE_OUT_O, .TX_NEG_PULSE_OUT_O, .IRQ_O, .AXI_AWADDR_I, .AXI_AWVALID_I,
    .AXI_AWREADY_O, .AXI_WDATA_I, .AXI_WVALID_I, .AXI_WREADY_O, .AXI_BRESP_O,
    .AXI_BVALID_O, .AXI_BREADY_I, .AXI_ARADDR_I, .AXI_ARVALID_I, .AXI_ARREADY_O,
    .AXI_RDATA_O, .AXI_RRESP_O, .AXI_RVALID_O);
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the T1 transmit clock block.
`timescale 1ns/100ps
`default_nettype none
`include "t1_txclk_defs.svh"
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h want %h", $time, (g), (e)); end end
module testbench;
    // ----
    // Signals
    // ----
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] tx_clock_in = 4'h0;
    logic [3:0] bpclk = 4'h0;
    logic [3:0] rxclk = 4'h0;
    logic [3:0] pos_d = 4'h0;
    logic [3:0] neg_d = 4'h0;
    logic [3:0] ser_d = 4'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] tx_clock_out, pos, neg;
    logic irq, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [15:0] rises, c;
    logic [1:0] bits;
    int n_mismatch = 0;
    int checked = 0;
    always #12.5 clk = ~clk;
    t1_txclk uut (.SYS_CLK_I(clk), .RESETN_I(rst_n), .TX_CLOCK_IN_I(tx_clock_in),
        .BACKPLANE_TX_CLOCK_I(bpclk), .RECOVERED_RX_CLOCK_I(rxclk), .TX_POS_DATA_I(pos_d),
        .TX_NEG_DATA_I(neg_d), .TX_SERIAL_DATA_I(ser_d), .TX_CLOCK_OUT_O(tx_clock_out),
        .TX_POS_PULSE_OUT_O(pos), .TX_NEG_PULSE_OUT_O(neg), .IRQ_O(irq),
        .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
        .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hf), .AXI_WVALID_I(wvalid),
        .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid),
        .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid),
        .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
        .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready));
    line_unit_model lum (.clk_i(clk), .rst_n_i(rst_n), .line_clk_i(tx_clock_out[0]),
        .pos_i(pos[0]), .neg_i(neg[0]), .rise_count_o(rises), .last_bits_o(bits));
    // ----
    // Bus and stimulus tasks
    // ----
    task automatic report_and_stop();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cfg_all(input logic [31:0] v);
        for (int i = 0; i < 4; i++)
            wr(8'(4 * i), v, r);
    endtask
    task automatic pulse(input logic [2:0] m, input int n);
        repeat (n)
        begin
            tx_clock_in <= {4{m[0]}};
            bpclk <= {4{m[1]}};
            rxclk <= {4{m[2]}};
            repeat (2) @(posedge clk);
            tx_clock_in <= 4'h0;
            bpclk <= 4'h0;
            rxclk <= 4'h0;
            repeat (2) @(posedge clk);
        end
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        rd(`REG_CFG0, d, r);
        `CHECK({r, d}, 34'h0); // default source
        wr(`REG_CFG1, 32'hff00, r);
        rd(`REG_CFG1, d, r);
        `CHECK(d, 32'hff00); // largest multiple
        wr(`REG_CFG1, 32'h0, r);
        wr(`REG_STATUS, 32'hffffffff, r);
        `CHECK(r, `RESP_OKAY);
        rd(8'h1c, d, r);
        `CHECK({r, d}, {`RESP_SLVERR, 32'h0});
        wr(8'h40, 32'h1, r);
        `CHECK(r, `RESP_SLVERR);
    endtask
    task automatic t_div8();
        pos_d <= 4'ha;
        neg_d <= 4'h5;
        pulse(3'b001, 3);
        `CHECK(tx_clock_out, 4'h0); // three rises
        pulse(3'b001, 1);
        `CHECK({tx_clock_out, pos, neg}, 12'hfa5);
        `CHECK(bits, 2'b01);
        pos_d <= 4'h3;
        pulse(3'b001, 4);
        `CHECK({tx_clock_out, pos}, 8'h0a); // held until rise
        cfg_all(32'h10);
        pulse(3'b001, 4);
        `CHECK({tx_clock_out, pos}, 8'hf3); // first half
        pulse(3'b001, 4);
        `CHECK({tx_clock_out, pos}, 8'h00); // second half
        cfg_all(32'h20);
        pos_d <= 4'hc;
        pulse(3'b001, 4);
        `CHECK({tx_clock_out, pos}, 8'hf0); // falling edge
        pulse(3'b001, 4);
        `CHECK({tx_clock_out, pos}, 8'h0c); // falling edge
    endtask
    task automatic t_loop();
        cfg_all(32'h04);
        c = rises;
        pulse(3'b001, 8);
        `CHECK(16'(rises - c), 16'h0); // input ignored
        pulse(3'b100, 8);
        `CHECK(16'(rises - c), 16'h1); // recovered used
    endtask
    task automatic t_direct();
        for (int s = 2; s < 4; s++)
        begin
            cfg_all(32'(s));
            bpclk <= (s == 2) ? 4'hf : 4'h0;
            rxclk <= (s == 3) ? 4'hf : 4'h0;
            repeat (3) @(posedge clk);
            `CHECK(tx_clock_out, 4'hf); // source selected
            bpclk <= 4'h0;
            rxclk <= 4'h0;
            repeat (3) @(posedge clk);
            `CHECK(tx_clock_out, 4'h0); // source selected
        end
    endtask
    task automatic t_fifo();
        ser_d <= 4'h6;
        cfg_all(32'h09);
        c = rises;
        repeat (2000) @(posedge clk);
        `CHECK(16'(rises - c) inside {[16'd74:16'd80]}, 1'b1);
        `CHECK({neg, pos}, 8'hf6);
        rd(`REG_STATUS, d, r);
        `CHECK(d[11:8], 4'hf); // near empty
        rd(`REG_INT_STAT, d, r);
        `CHECK({d, irq}, 33'h1e);
        wr(`REG_INT_MASK, 32'h1, r);
        repeat (3) @(posedge clk);
        `CHECK(irq, 1'b1);
        wr(`REG_INT_STAT, 32'hf, r);
        repeat (3) @(posedge clk);
        `CHECK(irq, 1'b0);
        wr(`REG_INT_MASK, 32'h0, r);
        cfg_all(32'h49);
        repeat (100) @(posedge clk);
        `CHECK(neg, 4'h0); // near full chosen
        c = rises;
        pulse(3'b001, 200);
        `CHECK(16'(rises - c) inside {[16'd34:16'd48]}, 1'b1); // steered faster
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_div8();
        t_loop();
        t_direct();
        t_fifo();
        report_and_stop();
    end
endmodule
`default_nettype wire
